//--- rtl/ramio_consts.vh
// constants for the muxed-bus ram / io / timer peripheral
// assumes inclusion by ramio_port and its bound checker; edge_fall and down_timer do not include it
`ifndef RAMIO_CONSTS_VH
`define RAMIO_CONSTS_VH
`define RAM_AW          7
`define OFS_PA_DATA     5'h00
`define OFS_PB_DATA     5'h01
`define OFS_PC_DATA     5'h02
`define OFS_PA_DIR      5'h04
`define OFS_PB_DIR      5'h05
`define OFS_PC_DIR      5'h06
`define OFS_MODE        5'h07
`define OFS_PA_CLR      5'h08
`define OFS_PB_CLR      5'h09
`define OFS_PC_CLR      5'h0a
`define OFS_PA_SET      5'h0c
`define OFS_PB_SET      5'h0d
`define OFS_PC_SET      5'h0e
`define OFS_T0_LO       5'h10
`define OFS_T0_HI       5'h11
`define OFS_T1_LO       5'h12
`define OFS_T1_HI       5'h13
`define OFS_T0_STOP     5'h14
`define OFS_T0_START    5'h15
`define OFS_T1_STOP     5'h16
`define OFS_T1_START    5'h17
`define OFS_T0_MODE     5'h18
`define OFS_T1_MODE     5'h19
`define MODE_BASIC      2'h0
`define MODE_STB_IN     2'h1
`define MODE_STB_OUT_A  2'h2
`define MODE_STB_OUT_Z  2'h3
`define BIT_IRQ         0
`define BIT_BUF_FULL    1
`define BIT_STROBE      2
`define BIT_GATE        3
`define BIT_T1_CLK      4
`define BIT_T1_OUT      5
`endif

//--- rtl/edge_fall.v
// falling-edge detector for a pin already synchronous to ref_clk
// assumes the input is glitch free at clock rate
module edge_fall (
    ref_clk,
    nrst,
    level_in,
    fall
);
    input  wire ref_clk;
    input  wire nrst;
    input  wire level_in;
    output wire fall;
    reg         last_q;
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            last_q <= 1'b1;
        end else begin
            last_q <= level_in;
        end
    end
    assign fall = last_q & ~level_in;
endmodule // edge_fall

//--- rtl/down_timer.v
// 16-bit down counter clocked by falling edges of an input pin
// assumes the pin is synchronous; output toggles on each terminal count
module down_timer #(
    parameter W = 16
) (
    ref_clk,
    nrst,
    srst,
    clk_pin,
    gate,
    run,
    load,
    load_val,
    count,
    out_q
);
    input  wire         ref_clk;
    input  wire         nrst;
    input  wire         srst;
    input  wire         clk_pin;
    input  wire         gate;
    input  wire         run;
    input  wire         load;
    input  wire [W-1:0] load_val;
    output reg  [W-1:0] count;
    output reg          out_q;
    wire                tick;
    edge_fall u_edge (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .level_in (clk_pin),
        .fall     (tick)
    );
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            count <= {W{1'b0}};
            out_q <= 1'b1;
        end else if (srst) begin
            count <= {W{1'b0}};
            out_q <= 1'b1;
        end else if (load) begin
            count <= load_val;
        end else if (run && gate && tick) begin
            if (count == {W{1'b0}}) begin
                count <= load_val;
                out_q <= ~out_q;
            end else begin
                count <= count - {{(W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule // down_timer

//--- rtl/ramio_port.v
// muxed address/data bus peripheral: 128x8 storage, three ports, two timers
// assumes all pins are synchronous to ref_clk; the bench resolves the
// bidirectional pins from the output enables
`include "ramio_consts.vh"
module ramio_port #(
    parameter RAM_DEPTH = 128
) (
    ref_clk,
    nrst,
    reset_in,
    addr_latch,
    chip_enable,
    io_timer_or_ram_select,
    read_n,
    write_n,
    mux_addr_data_bus_in,
    mux_addr_data_bus_out,
    mux_addr_data_bus_oe,
    port_a_pins_in,
    port_a_pins_out,
    port_a_pins_oe,
    port_b_pins_in,
    port_b_pins_out,
    port_b_pins_oe,
    port_c_pins_in,
    port_c_pins_out,
    port_c_pins_oe,
    timer0_clock_in,
    timer0_output
);
    input  wire       ref_clk;
    input  wire       nrst;
    input  wire       reset_in;
    input  wire       addr_latch;
    input  wire       chip_enable;
    input  wire       io_timer_or_ram_select;
    input  wire       read_n;
    input  wire       write_n;
    input  wire [7:0] mux_addr_data_bus_in;
    output reg  [7:0] mux_addr_data_bus_out;
    output reg        mux_addr_data_bus_oe;
    input  wire [7:0] port_a_pins_in;
    output reg  [7:0] port_a_pins_out;
    output reg  [7:0] port_a_pins_oe;
    input  wire [7:0] port_b_pins_in;
    output reg  [7:0] port_b_pins_out;
    output reg  [7:0] port_b_pins_oe;
    input  wire [5:0] port_c_pins_in;
    output reg  [5:0] port_c_pins_out;
    output reg  [5:0] port_c_pins_oe;
    input  wire       timer0_clock_in;
    output reg        timer0_output;

    reg  [7:0]  ram [0:RAM_DEPTH-1];
    reg  [7:0]  addr_q;
    reg         ce_q;
    reg         sel_io_q;
    reg  [7:0]  pa_q, pb_q, pa_dir_q, pb_dir_q, mode_q, pa_in_q;
    reg  [5:0]  pc_q, pc_dir_q;
    reg  [7:0]  t0_mode_q, t1_mode_q;
    reg  [15:0] t0_mod_q, t1_mod_q;
    reg         t0_run_q, t1_run_q;
    reg         full_q, irq_q, wr_last_q;
    reg  [7:0]  rd_data;
    wire        ale_fall, stb_fall, rd_fall;
    wire [15:0] t0_cnt, t1_cnt;
    wire        t0_out, t1_out;
    wire [4:0]  ofs = addr_q[4:0];
    wire        strobed = mode_q[0];
    wire [1:0]  pa_mode = mode_q[0] ? {mode_q[1], ~mode_q[1] | mode_q[2]}
                                    : `MODE_BASIC;
    wire        access = ce_q & ~addr_latch;
    wire        rd_act = access & ~read_n;
    wire        wr_act = access & ~write_n;
    wire        wr_pulse = wr_act & ~wr_last_q;
    wire        io_wr = wr_pulse & sel_io_q;
    wire        gate = port_c_pins_in[`BIT_GATE] | pc_dir_q[`BIT_GATE];

    edge_fall u_ale (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .level_in (addr_latch),
        .fall     (ale_fall)
    );
    edge_fall u_stb (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .level_in (port_c_pins_in[`BIT_STROBE]),
        .fall     (stb_fall)
    );
    edge_fall u_rd (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .level_in (read_n | ~access),
        .fall     (rd_fall)
    );
    down_timer #(.W(16)) u_t0 (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .srst     (reset_in),
        .clk_pin  (timer0_clock_in),
        .gate     (gate),
        .run      (t0_run_q),
        .load     (io_wr && ofs == `OFS_T0_HI),
        // the load must see the high byte being written this cycle
        .load_val (io_wr && ofs == `OFS_T0_HI
                   ? {mux_addr_data_bus_in, t0_mod_q[7:0]} : t0_mod_q),
        .count    (t0_cnt),
        .out_q    (t0_out)
    );
    down_timer #(.W(16)) u_t1 (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .srst     (reset_in),
        .clk_pin  (port_c_pins_in[`BIT_T1_CLK]),
        .gate     (gate),
        .run      (t1_run_q),
        .load     (io_wr && ofs == `OFS_T1_HI),
        .load_val (io_wr && ofs == `OFS_T1_HI
                   ? {mux_addr_data_bus_in, t1_mod_q[7:0]} : t1_mod_q),
        .count    (t1_cnt),
        .out_q    (t1_out)
    );

    // address capture: the latch strobe fall takes all three together
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            addr_q   <= 8'h00;
            ce_q     <= 1'b0;
            sel_io_q <= 1'b0;
        end else if (reset_in) begin
            addr_q   <= 8'h00;
            ce_q     <= 1'b0;
            sel_io_q <= 1'b0;
        end else if (ale_fall) begin
            addr_q   <= mux_addr_data_bus_in;
            ce_q     <= chip_enable;
            sel_io_q <= io_timer_or_ram_select;
        end
    end

    // storage has no reset so its contents survive the reset input
    always @(posedge ref_clk) begin
        if (wr_pulse && !sel_io_q) begin
            ram[addr_q[`RAM_AW-1:0]] <= mux_addr_data_bus_in;
        end
    end

    always @* begin
        rd_data = 8'h00;
        if (!sel_io_q) begin
            rd_data = ram[addr_q[`RAM_AW-1:0]];
        end else begin
            case (ofs)
                `OFS_PA_DATA: rd_data = (pa_q & pa_dir_q) |
                    ((pa_mode == `MODE_STB_IN ? pa_in_q : port_a_pins_in)
                     & ~pa_dir_q);
                `OFS_PB_DATA: rd_data = (pb_q & pb_dir_q) |
                                        (port_b_pins_in & ~pb_dir_q);
                `OFS_PC_DATA: rd_data = {2'h0, (pc_q & pc_dir_q) |
                                        (port_c_pins_in & ~pc_dir_q)};
                `OFS_T0_LO:   rd_data = t0_cnt[7:0];
                `OFS_T0_HI:   rd_data = t0_cnt[15:8];
                `OFS_T1_LO:   rd_data = t1_cnt[7:0];
                `OFS_T1_HI:   rd_data = t1_cnt[15:8];
                `OFS_T0_MODE: rd_data = t0_mode_q;
                `OFS_T1_MODE: rd_data = t1_mode_q;
                default:      rd_data = 8'h00;
            endcase
        end
    end

    // register writes; bit-set and bit-clear touch only the data latch
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pa_q <= 8'h00; pb_q <= 8'h00; pc_q <= 6'h00;
            pa_dir_q <= 8'h00; pb_dir_q <= 8'h00; pc_dir_q <= 6'h00;
            mode_q <= 8'h00; t0_mode_q <= 8'h00; t1_mode_q <= 8'h00;
            t0_mod_q <= 16'h0000; t1_mod_q <= 16'h0000;
            t0_run_q <= 1'b0; t1_run_q <= 1'b0; wr_last_q <= 1'b0;
        end else if (reset_in) begin
            pa_q <= 8'h00; pb_q <= 8'h00; pc_q <= 6'h00;
            pa_dir_q <= 8'h00; pb_dir_q <= 8'h00; pc_dir_q <= 6'h00;
            mode_q <= 8'h00; t0_mode_q <= 8'h00; t1_mode_q <= 8'h00;
            t0_mod_q <= 16'h0000; t1_mod_q <= 16'h0000;
            t0_run_q <= 1'b0; t1_run_q <= 1'b0; wr_last_q <= 1'b0;
        end else begin
            wr_last_q <= wr_act;
            if (io_wr) begin
                case (ofs)
                    `OFS_PA_DATA:  pa_q <= mux_addr_data_bus_in;
                    `OFS_PB_DATA:  pb_q <= mux_addr_data_bus_in;
                    `OFS_PC_DATA:  pc_q <= mux_addr_data_bus_in[5:0];
                    `OFS_PA_DIR:   pa_dir_q <= mux_addr_data_bus_in;
                    `OFS_PB_DIR:   pb_dir_q <= mux_addr_data_bus_in;
                    `OFS_PC_DIR:   pc_dir_q <= mux_addr_data_bus_in[5:0];
                    `OFS_MODE:     mode_q <= mux_addr_data_bus_in;
                    `OFS_PA_CLR:   pa_q <= pa_q & ~mux_addr_data_bus_in;
                    `OFS_PB_CLR:   pb_q <= pb_q & ~mux_addr_data_bus_in;
                    `OFS_PC_CLR:   pc_q <= pc_q & ~mux_addr_data_bus_in[5:0];
                    `OFS_PA_SET:   pa_q <= pa_q | mux_addr_data_bus_in;
                    `OFS_PB_SET:   pb_q <= pb_q | mux_addr_data_bus_in;
                    `OFS_PC_SET:   pc_q <= pc_q | mux_addr_data_bus_in[5:0];
                    `OFS_T0_LO:    t0_mod_q[7:0] <= mux_addr_data_bus_in;
                    `OFS_T0_HI:    t0_mod_q[15:8] <= mux_addr_data_bus_in;
                    `OFS_T1_LO:    t1_mod_q[7:0] <= mux_addr_data_bus_in;
                    `OFS_T1_HI:    t1_mod_q[15:8] <= mux_addr_data_bus_in;
                    `OFS_T0_STOP:  t0_run_q <= 1'b0;
                    `OFS_T0_START: t0_run_q <= 1'b1;
                    `OFS_T1_STOP:  t1_run_q <= 1'b0;
                    `OFS_T1_START: t1_run_q <= 1'b1;
                    `OFS_T0_MODE:  t0_mode_q <= mux_addr_data_bus_in;
                    `OFS_T1_MODE:  t1_mode_q <= mux_addr_data_bus_in;
                    default:       pa_q <= pa_q;
                endcase
            end
        end
    end

    // strobed handshake for port a; a peripheral strobe beats a cpu
    // access in the same cycle, so a strobed input byte is kept but a cpu write in that cycle leaves full clear
    wire cpu_pa = sel_io_q && ofs == `OFS_PA_DATA;
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            full_q <= 1'b0; irq_q <= 1'b1; pa_in_q <= 8'h00;
        end else if (reset_in || !strobed) begin
            full_q <= 1'b0; irq_q <= 1'b1; pa_in_q <= 8'h00;
        end else if (pa_mode == `MODE_STB_IN) begin
            if (stb_fall) begin
                pa_in_q <= port_a_pins_in;
                full_q  <= 1'b1;
                irq_q   <= 1'b0;
            end else if (rd_fall && cpu_pa) begin
                full_q  <= 1'b0;
                irq_q   <= 1'b1;
            end
        end else begin
            if (stb_fall) begin
                full_q <= 1'b0;
                irq_q  <= 1'b0;
            end else if (io_wr && ofs == `OFS_PA_DATA) begin
                full_q <= 1'b1;
                irq_q  <= 1'b1;
            end
        end
    end

    // registered pin and bus drivers
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mux_addr_data_bus_out <= 8'h00; mux_addr_data_bus_oe <= 1'b0;
            port_a_pins_out <= 8'h00; port_a_pins_oe <= 8'h00;
            port_b_pins_out <= 8'h00; port_b_pins_oe <= 8'h00;
            port_c_pins_out <= 6'h00; port_c_pins_oe <= 6'h00;
            timer0_output <= 1'b1;
        end else if (reset_in) begin
            // pin registers reset too (timer0_output goes high), not only the latches behind them
            mux_addr_data_bus_out <= 8'h00; mux_addr_data_bus_oe <= 1'b0;
            port_a_pins_out <= 8'h00; port_a_pins_oe <= 8'h00;
            port_b_pins_out <= 8'h00; port_b_pins_oe <= 8'h00;
            port_c_pins_out <= 6'h00; port_c_pins_oe <= 6'h00;
            timer0_output <= 1'b1;
        end else begin
            mux_addr_data_bus_out <= rd_data;
            mux_addr_data_bus_oe  <= rd_act & ~reset_in;
            timer0_output   <= reset_in ? 1'b1 : t0_out;
            port_a_pins_out <= pa_q;
            port_b_pins_out <= pb_q;
            port_b_pins_oe  <= reset_in ? 8'h00 : pb_dir_q;
            if (reset_in || pa_mode == `MODE_STB_IN) begin
                port_a_pins_oe <= 8'h00;
            end else if (pa_mode == `MODE_STB_OUT_Z) begin
                port_a_pins_oe <= port_c_pins_in[`BIT_STROBE] ? 8'h00
                                                               : 8'hff;
            end else if (pa_mode == `MODE_STB_OUT_A) begin
                port_a_pins_oe <= 8'hff;
            end else begin
                port_a_pins_oe <= pa_dir_q;
            end
            port_c_pins_out <= pc_q;
            port_c_pins_oe  <= reset_in ? 6'h00 : pc_dir_q;
            port_c_pins_out[`BIT_T1_OUT] <= t1_out;
            if (pc_dir_q[`BIT_T1_OUT] && !reset_in) begin
                port_c_pins_oe[`BIT_T1_OUT] <= 1'b1;
            end
            if (strobed && !reset_in) begin
                port_c_pins_out[`BIT_IRQ]      <= irq_q;
                port_c_pins_oe[`BIT_IRQ]       <= 1'b1;
                port_c_pins_out[`BIT_BUF_FULL] <= full_q;
                port_c_pins_oe[`BIT_BUF_FULL]  <= 1'b1;
                port_c_pins_oe[`BIT_STROBE]    <= 1'b0;
            end
        end
    end
endmodule // ramio_port

//--- bench/ramio_port_assertions.sv
// pin-level assertions for ramio_port, bound to every instance
// assumes latch and strobes are sampled on ref_clk
`include "ramio_consts.vh"
module ramio_port_checker (
    input wire       ref_clk,
    input wire       nrst,
    input wire       reset_in,
    input wire       addr_latch,
    input wire       chip_enable,
    input wire       io_timer_or_ram_select,
    input wire       read_n,
    input wire       write_n,
    input wire [7:0] mux_addr_data_bus_in,
    input wire       mux_addr_data_bus_oe,
    input wire [7:0] port_b_pins_oe,
    input wire [7:0] port_b_pins_out,
    input wire       timer0_output
);
    timeunit 1ns;
    timeprecision 1ns;
    reg       latch_q;
    reg       ce_cap;
    reg       sel_cap;
    reg [4:0] ofs_cap;
    wire      io_wr;

    // mirror of the address phase; no capture while sync reset is high
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            latch_q <= 1'b1;
            ce_cap  <= 1'b0;
            sel_cap <= 1'b0;
            ofs_cap <= 5'h00;
        end else begin
            latch_q <= addr_latch;
            if (reset_in) begin
                ce_cap <= 1'b0;
            end else if (latch_q && !addr_latch) begin
                ce_cap  <= chip_enable;
                sel_cap <= io_timer_or_ram_select;
                ofs_cap <= mux_addr_data_bus_in[4:0];
            end
        end
    end
    assign io_wr = ce_cap && sel_cap && !addr_latch && !reset_in;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    a_rd_drive: assert property (
        !read_n && !addr_latch && ce_cap && !reset_in
        |=> mux_addr_data_bus_oe)
        else $error("read strobe left the bus undriven");
    a_rd_release: assert property (
        mux_addr_data_bus_oe |-> !$past(read_n) && !$past(addr_latch))
        else $error("bus driven outside a read");
    a_ce_gate: assert property (
        mux_addr_data_bus_oe |-> ce_cap)
        else $error("bus driven with enable caught low");
    a_wr_quiet: assert property (
        $fell(write_n) && read_n |-> !mux_addr_data_bus_oe [*3])
        else $error("bus driven during a write");
    a_rst_bus: assert property (
        reset_in |=> !mux_addr_data_bus_oe && timer0_output)
        else $error("reset left bus or timer output wrong");
    a_rst_portb: assert property (
        reset_in |=> port_b_pins_oe == 8'h00 && port_b_pins_out == 8'h00)
        else $error("reset left port b registers set");
    a_pb_dir: assert property (
        io_wr && ofs_cap == `OFS_PB_DIR && $fell(write_n)
        |-> ##[1:2] port_b_pins_oe == mux_addr_data_bus_in)
        else $error("port b direction not written");
    a_pb_data: assert property (
        io_wr && ofs_cap == `OFS_PB_DATA && $fell(write_n)
        |-> ##[1:2] port_b_pins_out == mux_addr_data_bus_in)
        else $error("port b data not written");
endmodule // ramio_port_checker

bind ramio_port ramio_port_checker i_chk (
    .ref_clk, .nrst, .reset_in, .addr_latch, .chip_enable,
    .io_timer_or_ram_select, .read_n, .write_n, .mux_addr_data_bus_in,
    .mux_addr_data_bus_oe, .port_b_pins_oe, .port_b_pins_out,
    .timer0_output
);

//--- bench/host_cpu.sv
// host processor model on the multiplexed address/data bus
// assumes the device answers a read one edge after the strobe is seen
module host_cpu (
    input  wire       ref_clk,
    input  wire [7:0] dev_data,
    input  wire       dev_oe,
    output reg        addr_latch,
    output reg        chip_enable,
    output reg        io_timer_or_ram_select,
    output reg        read_n,
    output reg        write_n,
    output wire [7:0] bus_level
);
    timeunit 1ns;
    timeprecision 1ns;
    reg       drv;
    reg       saw_oe;
    reg [7:0] dval;
    reg [7:0] last_q;

    initial begin
        addr_latch = 1'b1;
        chip_enable = 1'b0;
        io_timer_or_ram_select = 1'b0;
        read_n = 1'b1;
        write_n = 1'b1;
        drv = 1'b0;
        saw_oe = 1'b0;
        dval = 8'h00;
        last_q = 8'h00;
    end
    // a released bus holds no charge: show the inverse of the last level
    assign bus_level = dev_oe ? dev_data : (drv ? dval : ~last_q);
    always @(posedge ref_clk) begin
        last_q <= bus_level;
        if (dev_oe)
            saw_oe <= 1'b1;
    end

    task access(input ce, input sel, input [7:0] adr, input wr,
                input [7:0] wdat, output [7:0] rdat);
        begin
            @(negedge ref_clk);
            addr_latch = 1'b1;
            chip_enable = ce;
            io_timer_or_ram_select = sel;
            drv = 1'b1;
            dval = adr;
            saw_oe = 1'b0;
            @(negedge ref_clk);
            addr_latch = 1'b0;
            @(negedge ref_clk);
            dval = wdat;
            drv = wr;
            if (wr)
                write_n = 1'b0;
            else
                read_n = 1'b0;
            repeat (2) @(negedge ref_clk);
            rdat = bus_level;
            read_n = 1'b1;
            write_n = 1'b1;
            @(negedge ref_clk);
            drv = 1'b0;
        end
    endtask
endmodule // host_cpu

//--- bench/test_muxed_bus_peripheral_pin_interface.sv
// self-checking bench for ramio_port driven by the host_cpu model
// assumes host_cpu and the bound checker are compiled before it
module test_muxed_bus_peripheral_pin_interface;
    timeunit 1ns;
    timeprecision 1ns;
    reg        ref_clk;
    reg        nrst;
    reg        reset_in;
    reg        timer0_clock_in;
    reg  [7:0] pa_drv;
    reg  [7:0] pb_drv;
    reg  [5:0] pc_drv;
    reg  [7:0] d;
    integer    err_count;
    integer    n_compared;
    integer    i;
    wire       addr_latch;
    wire       chip_enable;
    wire       io_timer_or_ram_select;
    wire       read_n;
    wire       write_n;
    wire       timer0_output;
    wire       bus_oe;
    wire [7:0] bus_level;
    wire [7:0] bus_out;
    wire [7:0] pa_out, pa_oe, pb_out, pb_oe;
    wire [5:0] pc_out, pc_oe;
    wire [7:0] pa_in = (pa_oe & pa_out) | (~pa_oe & pa_drv);
    wire [7:0] pb_in = (pb_oe & pb_out) | (~pb_oe & pb_drv);
    wire [5:0] pc_in = (pc_oe & pc_out) | (~pc_oe & pc_drv);

    ramio_port i_dut (
        .ref_clk, .nrst, .reset_in, .addr_latch, .chip_enable,
        .io_timer_or_ram_select, .read_n, .write_n,
        .mux_addr_data_bus_in (bus_level), .mux_addr_data_bus_out (bus_out),
        .mux_addr_data_bus_oe (bus_oe),
        .port_a_pins_in (pa_in), .port_a_pins_out (pa_out),
        .port_a_pins_oe (pa_oe), .port_b_pins_in (pb_in),
        .port_b_pins_out (pb_out), .port_b_pins_oe (pb_oe),
        .port_c_pins_in (pc_in), .port_c_pins_out (pc_out),
        .port_c_pins_oe (pc_oe), .timer0_clock_in, .timer0_output
    );
    host_cpu i_host (
        .ref_clk, .dev_data (bus_out), .dev_oe (bus_oe), .addr_latch,
        .chip_enable, .io_timer_or_ram_select, .read_n, .write_n,
        .bus_level
    );
    always #10 ref_clk = ~ref_clk;

    task chk(input [7:0] got, input [7:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task final_report;
        begin
            if (err_count == 0 && n_compared > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    task wr(input sel, input [7:0] a, input [7:0] v);
        i_host.access(1'b1, sel, a, 1'b1, v, d);
    endtask
    task rd(input sel, input [7:0] a);
        i_host.access(1'b1, sel, a, 1'b0, 8'h00, d);
    endtask

    // bit 7 of a storage address is ignored, so 8'h80 aliases 8'h00
    task t_ram;
        begin
            wr(1'b0, 8'h7f, 8'ha5);
            wr(1'b0, 8'h80, 8'h5a);
            wr(1'b0, 8'h01, 8'h99);
            rd(1'b0, 8'hff);
            chk(d, 8'ha5);
            rd(1'b0, 8'h00);
            chk(d, 8'h5a);
            i_host.access(1'b0, 1'b0, 8'h7f, 1'b1, 8'h11, d);
            rd(1'b0, 8'h7f);
            chk(d, 8'ha5);
            i_host.access(1'b0, 1'b0, 8'h7f, 1'b0, 8'h00, d);
            chk({7'h00, i_host.saw_oe}, 8'h00);
        end
    endtask
    task t_portb;
        begin
            wr(1'b1, 8'h05, 8'hff);
            wr(1'b1, 8'h01, 8'h3c);
            chk(pb_oe, 8'hff);
            chk(pb_out, 8'h3c);
            rd(1'b0, 8'h01);
            chk(d, 8'h99);
            wr(1'b1, 8'he5, 8'h00);
            pb_drv = 8'hc3;
            rd(1'b1, 8'h01);
            chk(d, 8'hc3);
        end
    endtask
    task t_reset_in;
        begin
            reset_in = 1'b1;
            @(negedge ref_clk);
            reset_in = 1'b0;
            @(negedge ref_clk);
            chk(pb_oe, 8'h00);
            chk({7'h00, timer0_output}, 8'h01);
            rd(1'b0, 8'h7f);
            chk(d, 8'ha5);
        end
    endtask
    task t_strobe;
        begin
            pa_drv = 8'h96;
            wr(1'b1, 8'h07, 8'h01);
            wr(1'b1, 8'h06, 8'h03);
            pc_drv[2] = 1'b0;
            repeat (3) @(negedge ref_clk);
            pc_drv[2] = 1'b1;
            repeat (2) @(negedge ref_clk);
            chk({6'h00, pc_out[1:0]}, 8'h02);
            rd(1'b1, 8'h00);
            chk(d, 8'h96);
            chk({6'h00, pc_out[1:0]}, 8'h01);
        end
    endtask
    // mode 3 drives port a only while the strobe is low; mode 2 always
    task t_strobe_out;
        begin
            wr(1'b1, 8'h07, 8'h07);
            wr(1'b1, 8'h00, 8'h5a);
            chk(pa_oe, 8'h00);
            chk({6'h00, pc_out[1:0]}, 8'h03);
            pc_drv[2] = 1'b0;
            repeat (2) @(negedge ref_clk);
            chk(pa_oe, 8'hff);
            chk(pa_out, 8'h5a);
            chk({6'h00, pc_out[1:0]}, 8'h00);
            pc_drv[2] = 1'b1;
            repeat (2) @(negedge ref_clk);
            chk(pa_oe, 8'h00);
            wr(1'b1, 8'h07, 8'h03);
            chk(pa_oe, 8'hff);
        end
    endtask
    // gate comes from port c bit 3, left an input and held high
    task t_timer;
        begin
            wr(1'b1, 8'h10, 8'h02);
            wr(1'b1, 8'h11, 8'h00);
            wr(1'b1, 8'h15, 8'h00);
            for (i = 0; i < 8 && timer0_output === 1'b1; i = i + 1) begin
                timer0_clock_in = 1'b1;
                repeat (2) @(negedge ref_clk);
                timer0_clock_in = 1'b0;
                repeat (2) @(negedge ref_clk);
            end
            chk({7'h00, timer0_output}, 8'h00);
            if (timer0_output !== 1'b0)
                final_report;
            // timer 1: modulus zero toggles its pin on every clock fall
            wr(1'b1, 8'h06, 8'h23);
            wr(1'b1, 8'h13, 8'h00);
            wr(1'b1, 8'h17, 8'h00);
            chk({7'h00, pc_out[5]}, 8'h01);
            pc_drv[4] = 1'b1;
            repeat (2) @(negedge ref_clk);
            pc_drv[4] = 1'b0;
            repeat (2) @(negedge ref_clk);
            chk({7'h00, pc_out[5]}, 8'h00);
        end
    endtask

    initial begin
        ref_clk = 1'b0;
        nrst = 1'b0;
        reset_in = 1'b0;
        timer0_clock_in = 1'b0;
        pa_drv = 8'h00;
        pb_drv = 8'h00;
        pc_drv = 6'h0c;
        err_count = 0;
        n_compared = 0;
        repeat (6) @(negedge ref_clk);
        nrst = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk({7'h00, timer0_output}, 8'h01);
        chk({7'h00, bus_oe}, 8'h00);
        t_ram;
        t_portb;
        t_reset_in;
        t_strobe;
        t_strobe_out;
        t_timer;
        final_report;
    end
endmodule // test_muxed_bus_peripheral_pin_interface
